// file: pkg/gpp_pkg.sv
// General-purpose pin port: register map, reset values and pin carriers.
// Assumes an 8-bit register address space reached through the host interface.
package gpp_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] ADDR_FUNC_SEL = 8'h4F;
  localparam logic [7:0] ADDR_OUT_LVL = 8'h50;
  localparam logic [7:0] ADDR_DIR = 8'h51;
  localparam logic [7:0] ADDR_IN_LVL = 8'h52;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_FUNC_SEL = 8'h00;
  localparam logic [7:0] RST_OUT_LVL = 8'h00;
  localparam logic [7:0] RST_DIR = 8'hFF;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // ==========================================================================
  // Field and pin positions
  localparam int unsigned PIN_COUNT = 8;
  localparam int unsigned FS_PIN7_BIT = 7;
  localparam int unsigned FS_PIN65_BIT = 6;
  localparam int unsigned PIN_IRQ = 7;
  localparam int unsigned PIN_RSVD_ALT = 6;
  localparam int unsigned PIN_SYNC = 5;
  localparam int unsigned PIN_ANT_DIR = 1;
  localparam int unsigned PIN_ANT_CTL = 0;
  // Bit 1 never follows a general-purpose pin
  localparam logic [7:0] GP_MASK = 8'hFD;
  localparam logic [7:0] FS_WR_MASK = 8'hC0;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } gpp_wr_t;

  typedef struct packed {
    logic [7:0] level;
    logic [7:0] oe_n;
  } gpp_pins_t;

endpackage : gpp_pkg

// file: logic/gpp_port.sv
// General-purpose pin port: function select, output levels, direction, input levels.
// Assumes the host interface and alternate-function sources share clk_i; pin inputs
// are asynchronous and are synchronised here.
module gpp_port (
  input wire logic clk_i, // 25 MHz device clock
  input wire logic rstn_i, // Power-on reset, async, active low
  input wire logic wr_en_i, // Register write strobe, one cycle
  input wire gpp_pkg::gpp_wr_t wr_i, // Write address and data
  input wire logic rd_en_i, // Register read strobe, one cycle
  input wire logic [7:0] rd_addr_i, // Read address
  output logic [7:0] rd_data_o, // Read data, valid cycle after strobe
  input wire logic [7:0] pin_in_i, // Pad input levels, asynchronous
  output gpp_pkg::gpp_pins_t pin_o, // Pad drive levels and enables
  input wire logic host_irq_i, // Interrupt request source
  input wire logic sync_src_i, // Sync output source
  input wire logic antenna_two_pin_i, // Antenna pin-mode select, 1 = two-pin
  input wire logic antenna_tx_active_i, // Antenna line driven by device
  output logic antenna_control_input_o // Antenna control input from pin 0
);

  // ==========================================================================
  // Registers
  logic sel7_q;
  logic sel6_q;
  logic [7:0] out_lvl_q;
  logic [7:0] dir_q;
  logic [7:0] rd_data_q;
  logic [7:0] in_meta_q;
  logic [7:0] in_sync_q;
  gpp_pkg::gpp_pins_t pins_q;
  gpp_pkg::gpp_pins_t pins_d;
  logic [7:0] func_sel;
  logic [7:0] rd_data_d;

  // Decides whether a pin currently belongs to general-purpose use
  function automatic logic gp_owned(input int unsigned idx, input logic s7, input logic s6,
                                    input logic two_pin);
    logic owned;
    owned = 1'b1;
    case (idx)
      gpp_pkg::PIN_IRQ: owned = !s7;
      gpp_pkg::PIN_RSVD_ALT: owned = !s6;
      gpp_pkg::PIN_SYNC: owned = !s6;
      gpp_pkg::PIN_ANT_DIR: owned = 1'b0;
      gpp_pkg::PIN_ANT_CTL: owned = !two_pin;
      default: owned = 1'b1;
    endcase
    return owned;
  endfunction : gp_owned

  function automatic logic wr_hit(input logic en, input gpp_pkg::gpp_wr_t w,
                                  input logic [7:0] a);
    return en && (w.addr == a);
  endfunction : wr_hit

  // ==========================================================================
  // Function select: only the top two bits hold state
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sel7_q <= gpp_pkg::RST_FUNC_SEL[gpp_pkg::FS_PIN7_BIT];
      sel6_q <= gpp_pkg::RST_FUNC_SEL[gpp_pkg::FS_PIN65_BIT];
    end else if (wr_hit(wr_en_i, wr_i, gpp_pkg::ADDR_FUNC_SEL)) begin
      sel7_q <= wr_i.data[gpp_pkg::FS_PIN7_BIT];
      sel6_q <= wr_i.data[gpp_pkg::FS_PIN65_BIT];
    end
  end

  // Reserved positions have no storage, so writes cannot reach them
  assign func_sel = gpp_pkg::FS_WR_MASK & {sel7_q, sel6_q, 6'h00};

  // ==========================================================================
  // Output levels
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      out_lvl_q <= gpp_pkg::RST_OUT_LVL;
    end else if (wr_hit(wr_en_i, wr_i, gpp_pkg::ADDR_OUT_LVL)) begin
      out_lvl_q <= wr_i.data;
    end
  end

  // ==========================================================================
  // Direction
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dir_q <= gpp_pkg::RST_DIR;
    end else if (wr_hit(wr_en_i, wr_i, gpp_pkg::ADDR_DIR)) begin
      dir_q <= wr_i.data;
    end
  end

  // ==========================================================================
  // Pin input synchroniser
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      in_meta_q <= gpp_pkg::ZERO_BYTE;
      in_sync_q <= gpp_pkg::ZERO_BYTE;
    end else begin
      in_meta_q <= pin_in_i;
      in_sync_q <= in_meta_q;
    end
  end

  // Only the two-pin mode hands the pin level to the antenna interface
  assign antenna_control_input_o = antenna_two_pin_i && in_sync_q[gpp_pkg::PIN_ANT_CTL];

  // ==========================================================================
  // Pin drive
  generate
    for (genvar i = 0; i < gpp_pkg::PIN_COUNT; i++) begin : g_pin
      always_comb begin
        pins_d.level[i] = 1'b0;
        pins_d.oe_n[i] = 1'b1;
        if (gp_owned(i, sel7_q, sel6_q, antenna_two_pin_i)) begin
          pins_d.level[i] = out_lvl_q[i];
          pins_d.oe_n[i] = dir_q[i];
        end else if (i == gpp_pkg::PIN_IRQ) begin
          pins_d.level[i] = host_irq_i;
          pins_d.oe_n[i] = 1'b0;
        end else if (i == gpp_pkg::PIN_SYNC) begin
          pins_d.level[i] = sync_src_i;
          pins_d.oe_n[i] = 1'b0;
        end else if (i == gpp_pkg::PIN_ANT_DIR) begin
          pins_d.level[i] = antenna_tx_active_i;
          pins_d.oe_n[i] = 1'b0;
        end
        // Reserved pin 6 and antenna input pin 0 stay released
      end
    end
  endgenerate

  // Registered so pads never see decode glitches; costs one cycle of latency
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pins_q.level <= gpp_pkg::ZERO_BYTE;
      pins_q.oe_n <= gpp_pkg::RST_DIR;
    end else begin
      pins_q <= pins_d;
    end
  end

  assign pin_o = pins_q;

  // ==========================================================================
  // Read path
  always_comb begin
    case (rd_addr_i)
      gpp_pkg::ADDR_FUNC_SEL: rd_data_d = func_sel;
      gpp_pkg::ADDR_OUT_LVL: rd_data_d = out_lvl_q;
      gpp_pkg::ADDR_DIR: rd_data_d = dir_q;
      gpp_pkg::ADDR_IN_LVL: rd_data_d = in_sync_q & gpp_pkg::GP_MASK;
      default: rd_data_d = gpp_pkg::ZERO_BYTE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_data_q <= gpp_pkg::ZERO_BYTE;
    end else if (rd_en_i) begin
      rd_data_q <= rd_data_d;
    end
  end

  assign rd_data_o = rd_data_q;

  // ==========================================================================
  // Checks
  logic wr_seen_q;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_seen_q <= 1'b0;
    end else if (wr_en_i) begin
      wr_seen_q <= 1'b1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  irq_route_a: assert property (
    sel7_q |=> (pin_o.level[gpp_pkg::PIN_IRQ] == $past(host_irq_i))
               && !pin_o.oe_n[gpp_pkg::PIN_IRQ])
    else $error("Pin 7 does not carry the interrupt request");

  gp7_route_a: assert property (
    !sel7_q |=> (pin_o.level[gpp_pkg::PIN_IRQ] == $past(out_lvl_q[gpp_pkg::PIN_IRQ]))
                && (pin_o.oe_n[gpp_pkg::PIN_IRQ] == $past(dir_q[gpp_pkg::PIN_IRQ])))
    else $error("Pin 7 does not follow its general-purpose bits");

  sync_route_a: assert property (
    sel6_q |=> (pin_o.level[gpp_pkg::PIN_SYNC] == $past(sync_src_i))
               && !pin_o.oe_n[gpp_pkg::PIN_SYNC] && pin_o.oe_n[gpp_pkg::PIN_RSVD_ALT])
    else $error("Pin 5 or pin 6 wrong under sync function");

  fsel_rsvd_a: assert property (
    (rd_en_i && rd_addr_i == gpp_pkg::ADDR_FUNC_SEL) |=> (rd_data_o[5:0] == 6'h00)
    && (rd_data_o[7:6] == $past({sel7_q, sel6_q})))
    else $error("Function select readback wrong");

  ant_dir_a: assert property (
    rstn_i |=> (pin_o.level[gpp_pkg::PIN_ANT_DIR] == $past(antenna_tx_active_i))
               && !pin_o.oe_n[gpp_pkg::PIN_ANT_DIR])
    else $error("Pin 1 does not show antenna direction");

  ant_ctl_a: assert property (
    antenna_two_pin_i |=> pin_o.oe_n[gpp_pkg::PIN_ANT_CTL])
    else $error("Pin 0 driven in two-pin antenna mode");

  out_wr_a: assert property (
    wr_hit(wr_en_i, wr_i, gpp_pkg::ADDR_OUT_LVL) && !sel7_q ##1 !sel7_q
    |=> pin_o.level[gpp_pkg::PIN_IRQ] == $past(wr_i.data[gpp_pkg::PIN_IRQ], 2))
    else $error("Output level write did not reach pin 7");

  dir_wr_a: assert property (
    wr_hit(wr_en_i, wr_i, gpp_pkg::ADDR_DIR) |=> dir_q == $past(wr_i.data))
    else $error("Direction write lost");

  reset_val_a: assert property (
    !wr_seen_q |-> (dir_q == gpp_pkg::RST_DIR) && (func_sel == gpp_pkg::RST_FUNC_SEL)
                   && (out_lvl_q == gpp_pkg::RST_OUT_LVL))
    else $error("Register left its reset value without a write");

  in_read_a: assert property (
    (rd_en_i && rd_addr_i == gpp_pkg::ADDR_IN_LVL)
    |=> rd_data_o == ($past(in_sync_q) & gpp_pkg::GP_MASK))
    else $error("Input level readback wrong");

  // ==========================================================================
  // Ownership, hold and readback checks

  out_rd_a: assert property (
    (rd_en_i && rd_addr_i == gpp_pkg::ADDR_OUT_LVL) |=> rd_data_o == $past(out_lvl_q))
    else $error("Output level readback wrong");

  dir_rd_a: assert property (
    (rd_en_i && rd_addr_i == gpp_pkg::ADDR_DIR) |=> rd_data_o == $past(dir_q))
    else $error("Direction readback wrong");

  rsvd_pin_a: assert property (
    sel6_q |=> pin_o.oe_n[gpp_pkg::PIN_RSVD_ALT] && !pin_o.level[gpp_pkg::PIN_RSVD_ALT])
    else $error("Reserved pin 6 not released under sync function");

  gp65_route_a: assert property (
    !sel6_q |=> (pin_o.level[gpp_pkg::PIN_SYNC] == $past(out_lvl_q[gpp_pkg::PIN_SYNC]))
                && (pin_o.oe_n[gpp_pkg::PIN_SYNC] == $past(dir_q[gpp_pkg::PIN_SYNC]))
                && (pin_o.level[gpp_pkg::PIN_RSVD_ALT] == $past(out_lvl_q[gpp_pkg::PIN_RSVD_ALT]))
                && (pin_o.oe_n[gpp_pkg::PIN_RSVD_ALT] == $past(dir_q[gpp_pkg::PIN_RSVD_ALT])))
    else $error("Pins 5 and 6 do not follow their general-purpose bits");

  gp0_route_a: assert property (
    !antenna_two_pin_i
    |=> (pin_o.level[gpp_pkg::PIN_ANT_CTL] == $past(out_lvl_q[gpp_pkg::PIN_ANT_CTL]))
        && (pin_o.oe_n[gpp_pkg::PIN_ANT_CTL] == $past(dir_q[gpp_pkg::PIN_ANT_CTL])))
    else $error("Pin 0 does not follow its general-purpose bits");

  ant_pin_idle_a: assert property (
    antenna_two_pin_i |=> !pin_o.level[gpp_pkg::PIN_ANT_CTL])
    else $error("Pin 0 level not idle in two-pin antenna mode");

  ant_in_off_a: assert property (
    !antenna_two_pin_i |-> !antenna_control_input_o)
    else $error("Antenna control input active outside two-pin mode");

  reset_pins_a: assert property (
    !wr_seen_q |-> ((pin_o.oe_n & gpp_pkg::GP_MASK) == gpp_pkg::GP_MASK))
    else $error("General-purpose pin driven before any write");

  // Three quiet cycles let both stages settle, even right after reset
  sync_delay_a: assert property (
    (rstn_i && $stable(pin_in_i)) [*3] |-> (in_sync_q == $past(pin_in_i)))
    else $error("Synchronised pin levels lag or differ");

  // Registers move only on a write to their own address, read data only on a read strobe
  out_hold_a: assert property (
    !wr_hit(wr_en_i, wr_i, gpp_pkg::ADDR_OUT_LVL) |=> $stable(out_lvl_q))
    else $error("Output levels changed without a write");

  dir_hold_a: assert property (
    !wr_hit(wr_en_i, wr_i, gpp_pkg::ADDR_DIR) |=> $stable(dir_q))
    else $error("Direction changed without a write");

  fsel_hold_a: assert property (
    !wr_hit(wr_en_i, wr_i, gpp_pkg::ADDR_FUNC_SEL) |=> $stable(func_sel))
    else $error("Function select changed without a write");

  in_lvl_ro_a: assert property (
    wr_hit(wr_en_i, wr_i, gpp_pkg::ADDR_IN_LVL)
    |=> $stable(out_lvl_q) && $stable(dir_q) && $stable(func_sel))
    else $error("Write to input levels changed a register");

  rd_hold_a: assert property (
    !rd_en_i |=> $stable(rd_data_o))
    else $error("Read data changed without a read strobe");

endmodule : gpp_port

// file: tb/gpp_board.sv
// Board model at the pads: resolves each pad from device drive and outside drive.
// Assumes pad levels return to the block asynchronously, with no delay.
module gpp_board (
  input wire gpp_pkg::gpp_pins_t pins_i, // Device drive levels and enables
  input wire logic [7:0] ext_i, // Levels driven by board parts
  output logic [7:0] pad_o // Resolved pad levels
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Pad resolution
  // A released pad shows the board level, never the last device level
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pad_o[i] = pins_i.oe_n[i] ? ext_i[i] : pins_i.level[i];
    end
  end
endmodule : gpp_board

// file: tb/testbench.sv
// Self-checking bench for the general-purpose pin port.
// Assumes one 25 MHz clock and register access through the internal strobe port.
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin err_total++; \
  $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rstn_i, wr_en_i, rd_en_i, host_irq_i, sync_src_i;
  logic antenna_two_pin_i, antenna_tx_active_i, antenna_control_input_o;
  gpp_pkg::gpp_wr_t wr_i;
  gpp_pkg::gpp_pins_t pin_o;
  logic [7:0] rd_addr_i, rd_data_o, pin_in_i, ext_q, rd_v;
  int err_total, tests_run, cyc;
  // ==========================================================================
  // Design and board
  gpp_port dut_u (.clk_i(clk_i), .rstn_i(rstn_i), .wr_en_i(wr_en_i), .wr_i(wr_i),
    .rd_en_i(rd_en_i), .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o), .pin_in_i(pin_in_i),
    .pin_o(pin_o), .host_irq_i(host_irq_i), .sync_src_i(sync_src_i),
    .antenna_two_pin_i(antenna_two_pin_i), .antenna_tx_active_i(antenna_tx_active_i),
    .antenna_control_input_o(antenna_control_input_o));
  gpp_board board_u (.pins_i(pin_o), .ext_i(ext_q), .pad_o(pin_in_i));
  // ==========================================================================
  // Clock and watchdog
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // Whole sequence needs under 200 cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      stop_test();
    end
  end
  // ==========================================================================
  // Access tasks
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_en_i <= 1'b1;
    wr_i <= '{addr: a, data: d};
    @(posedge clk_i);
    wr_en_i <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a);
    @(posedge clk_i);
    rd_en_i <= 1'b1;
    rd_addr_i <= a;
    @(posedge clk_i);
    rd_en_i <= 1'b0;
    #1 rd_v = rd_data_o;
  endtask : reg_rd
  // Register to pad takes one edge, pad to sync two more
  task automatic settle();
    repeat (4) @(posedge clk_i);
    #1;
  endtask : settle
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test
  // ==========================================================================
  // Sequence
  initial begin
    rstn_i = 1'b0;
    wr_en_i = 1'b0;
    rd_en_i = 1'b0;
    wr_i = '0;
    rd_addr_i = 8'h00;
    host_irq_i = 1'b0;
    sync_src_i = 1'b0;
    antenna_two_pin_i = 1'b0;
    antenna_tx_active_i = 1'b0;
    ext_q = 8'h5A;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    settle();
    `CHK("oe_n reset", 8'hFD, pin_o.oe_n)
    `CHK("level reset", 8'h00, pin_o.level)
    reg_rd(gpp_pkg::ADDR_FUNC_SEL);
    `CHK("func reset", 8'h00, rd_v)
    reg_rd(gpp_pkg::ADDR_OUT_LVL);
    `CHK("out reset", 8'h00, rd_v)
    reg_rd(gpp_pkg::ADDR_DIR);
    `CHK("dir reset", 8'hFF, rd_v)
    reg_rd(gpp_pkg::ADDR_IN_LVL);
    `CHK("in board", 8'h58, rd_v)
    reg_rd(8'h60);
    `CHK("unmapped", 8'h00, rd_v)
    @(posedge clk_i);
    host_irq_i <= 1'b1;
    sync_src_i <= 1'b1;
    reg_wr(gpp_pkg::ADDR_FUNC_SEL, 8'hFF);
    reg_rd(gpp_pkg::ADDR_FUNC_SEL);
    `CHK("func rsvd", 8'hC0, rd_v)
    settle();
    `CHK("alt oe_n", 8'h5D, pin_o.oe_n)
    `CHK("alt level", 8'hA0, pin_o.level)
    reg_wr(gpp_pkg::ADDR_FUNC_SEL, 8'h00);
    reg_wr(gpp_pkg::ADDR_OUT_LVL, 8'hA7);
    reg_wr(gpp_pkg::ADDR_DIR, 8'h00);
    settle();
    `CHK("gp oe_n", 8'h00, pin_o.oe_n)
    `CHK("gp level", 8'hA5, pin_o.level)
    reg_rd(gpp_pkg::ADDR_IN_LVL);
    `CHK("in driven", 8'hA5, rd_v)
    reg_rd(gpp_pkg::ADDR_OUT_LVL);
    `CHK("out readback", 8'hA7, rd_v)
    reg_rd(gpp_pkg::ADDR_DIR);
    `CHK("dir readback", 8'h00, rd_v)
    @(posedge clk_i);
    host_irq_i <= 1'b0;
    sync_src_i <= 1'b0;
    reg_wr(gpp_pkg::ADDR_FUNC_SEL, 8'hC0);
    settle();
    `CHK("alt over gp oe_n", 8'h40, pin_o.oe_n)
    `CHK("alt over gp level", 8'h05, pin_o.level)
    `CHK("ant ctl off", 1'b0, antenna_control_input_o)
    @(posedge clk_i);
    antenna_tx_active_i <= 1'b1;
    settle();
    `CHK("ant dir tx", 1'b1, pin_o.level[1])
    @(posedge clk_i);
    antenna_tx_active_i <= 1'b0;
    antenna_two_pin_i <= 1'b1;
    ext_q <= 8'h5B;
    settle();
    `CHK("ant dir rx", 1'b0, pin_o.level[1])
    `CHK("pin0 released", 1'b1, pin_o.oe_n[0])
    `CHK("ant ctl in", 1'b1, antenna_control_input_o)
    // Mid-run reset must restore every register and release the general-purpose pins
    @(posedge clk_i);
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    settle();
    `CHK("oe_n re-reset", 8'hFD, pin_o.oe_n)
    reg_wr(gpp_pkg::ADDR_IN_LVL, 8'h00);
    reg_rd(gpp_pkg::ADDR_DIR);
    `CHK("dir re-reset", 8'hFF, rd_v)
    reg_rd(gpp_pkg::ADDR_FUNC_SEL);
    `CHK("func re-reset", 8'h00, rd_v)
    reg_rd(gpp_pkg::ADDR_OUT_LVL);
    `CHK("out re-reset", 8'h00, rd_v)
    stop_test();
  end
endmodule : testbench
